// ===== verilog/cis_pkg.sv
// constants, types and register map of the interrupt sequencer
// assumes a 16-bit word-addressed program space and a byte stack
package cis_pkg;

	localparam int N_SRC = 8;
	localparam int SRC_W = 3;
	localparam int ADDR_W = 16;

	// boot section start, in program words
	localparam logic [15:0] BOOT_START = 16'h3800;
	// vector slots: reset owns slot 0, source i owns slot i+1, two words each
	localparam logic [N_SRC-1:0][7:0] VEC_IDX = {8'h08, 8'h07, 8'h06, 8'h05,
		8'h04, 8'h03, 8'h02, 8'h01};
	localparam logic [15:0] RESET_SLOT = 16'h0000;
	// sources that are level type, all others are flag type
	localparam logic [N_SRC-1:0] LEVEL_MASK = 8'h80;

	localparam logic [2:0] WAKE_CYC = 3'h4;
	localparam logic [15:0] SP_STEP = 16'h0001;
	localparam logic [15:0] SP_RESET = 16'h0000;

	// register word index (adr[4:2])
	localparam logic [2:0] REG_FLAG = 3'h0;
	localparam logic [2:0] REG_ENABLE = 3'h1;
	localparam logic [2:0] REG_STATUS = 3'h2;
	localparam logic [2:0] REG_MCU_CTRL = 3'h3;
	localparam logic [2:0] REG_STACK = 3'h4;
	localparam logic [2:0] REG_STATE = 3'h5;
	localparam int GIE_BIT = 7;
	localparam int VECTOR_TABLE_SELECT_BIT = 0;

	typedef enum logic [3:0] {
		S_IDLE, S_WAKE, S_PUSH_LO, S_PUSH_HI, S_ENT3, S_ENT4,
		S_POP_HI, S_POP_LO, S_RT3, S_RT4
	} cis_state_t;

	// one-cycle marks from the instruction pipeline
	typedef struct packed {
		logic boundary;
		logic cli;
		logic sei;
		logic return_from_irq_instr;
		logic sleeping;
	} cis_core_evt_t;

	// stack port toward data memory
	typedef struct packed {
		logic we;
		logic re;
		logic [15:0] addr;
		logic [7:0] wdata;
	} cis_stk_t;

endpackage

// ===== verilog/cis_top.sv
// interrupt and reset vectoring sequencer of an 8-bit core
// assumes the pipeline marks instruction ends, stalls on core_hold_o and
// that the stack memory returns read data one cycle after stk_o.re
//
// Function
// [R1] reset and each source have their own vector; service fetches it
// [R2] service only with source enable and global enable both set
// [R3] lowest vector wins; reset highest, comparator 0 next
// [R4] vector_table_select moves vectors to boot section start
// [R5] reset_vector_boot_fuse moves reset vector to boot section start
// [R6] boot lock bits suppress interrupts depending on program counter
// [R7] accepting an interrupt clears global enable; software may re-set it
// [R8] return from interrupt sets global enable
// [R9] hardware clears a flag-type source flag when vectoring to it
// [R10] writing one clears a flag, zero leaves it
// [R11] flags set while disabled are held until enabled or cleared
// [R12] flags held while global enable off are served in priority order
// [R13] level sources request only while present, no flag kept
// [R14] after return one more instruction runs before next service
// [R15] status register is neither saved nor restored
// [R16] clear-global-enable blocks service at once, same cycle included
// [R17] instruction after set-global-enable runs before any service
// [R18] entry takes four cycles pushing program counter, then vector
// [R19] multi-cycle instruction completes before entry starts
// [R20] waking from sleep adds four cycles to entry
// [R21] return takes four cycles, pops counter, stack pointer plus two
// [R22] entry push lowers stack pointer by two
// [R23] global enable is status bit 7
// [R24] arbitration only at instruction ends, winner registered
// [R25] vector is index table entry added to selected base
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module cis_top
	import cis_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// interrupt sources
	input wire logic [N_SRC-1:0] irq_event_i,
	input wire logic [N_SRC-1:0] irq_level_i,
	// fuses and lock bits
	input wire logic reset_vector_boot_fuse_i,
	input wire logic app_boot_lock_bit_i,
	input wire logic boot_section_lock_bit_i,
	// instruction pipeline
	input wire cis_core_evt_t core_evt_i,
	input wire logic [15:0] program_counter_i,
	output logic core_hold_o,
	output logic irq_take_o,
	output logic [15:0] vec_addr_o,
	output logic [15:0] rst_vec_o,
	output logic ret_valid_o,
	output logic [15:0] ret_pc_o,
	output logic gie_o,
	// stack memory
	output cis_stk_t stk_o,
	input wire logic [7:0] stk_rdata_i
);

////////////////////////////////////////////////////////////////////////////////
// register bus

logic ack_q, ack_d;
logic [31:0] rdat_q, rdat_d;
logic [N_SRC-1:0] en_q, en_d;
logic vector_table_select_q, vector_table_select_d;
logic [N_SRC-1:0] flag_q, flag_d;
logic bus_wr, bus_rd;
logic [N_SRC-1:0] w1c;
logic gie_q, gie_d;
logic [15:0] sp_q, sp_d;
cis_state_t st_q, st_d;
logic [SRC_W-1:0] win_q, win_d;
logic [N_SRC-1:0] take_clr;

assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
assign bus_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
assign w1c = (bus_wr && wb_adr_i[4:2] == REG_FLAG && wb_sel_i[0]) ?
	wb_dat_i[N_SRC-1:0] : '0; // R10

always_comb
begin
	ack_d = wb_cyc_i && wb_stb_i && !ack_q;
	rdat_d = rdat_q;
	en_d = en_q;
	vector_table_select_d = vector_table_select_q;
	if (bus_wr && wb_sel_i[0])
	begin
		if (wb_adr_i[4:2] == REG_ENABLE)
			en_d = wb_dat_i[N_SRC-1:0];
		if (wb_adr_i[4:2] == REG_MCU_CTRL)
			vector_table_select_d = wb_dat_i[VECTOR_TABLE_SELECT_BIT];
	end
	if (bus_rd)
	begin
		rdat_d = '0;
		unique case (wb_adr_i[4:2])
			// level sources show their live condition
			REG_FLAG: rdat_d[N_SRC-1:0] = (flag_q & ~LEVEL_MASK) | (irq_level_i & LEVEL_MASK);
			REG_ENABLE: rdat_d[N_SRC-1:0] = en_q;
			REG_STATUS: rdat_d[GIE_BIT] = gie_q; // R23
			REG_MCU_CTRL: rdat_d[VECTOR_TABLE_SELECT_BIT] = vector_table_select_q;
			REG_STACK: rdat_d[15:0] = sp_q;
			REG_STATE: rdat_d[7:0] = {st_q, 1'b0, win_q};
			default: rdat_d = '0;
		endcase
	end
end

always_ff @(posedge clk_i)
begin
	if (rst_i)
	begin
		ack_q <= 1'b0;
		rdat_q <= '0;
		en_q <= '0;
		vector_table_select_q <= 1'b0;
	end
	else
	begin
		ack_q <= ack_d;
		rdat_q <= rdat_d;
		en_q <= en_d;
		vector_table_select_q <= vector_table_select_d;
	end
end

assign wb_ack_o = ack_q;
assign wb_dat_o = rdat_q;

////////////////////////////////////////////////////////////////////////////////
// flags and arbitration

logic [N_SRC-1:0] req;
logic found;
logic lock_sup;
logic can_take;
logic skip_q, skip_d;

// a new event in the clearing cycle survives: set wins
always_comb
begin
	flag_d = (flag_q & ~(w1c | take_clr)) | (irq_event_i & ~LEVEL_MASK); // R9 R10 R11 R12
end

always_ff @(posedge clk_i)
begin
	if (rst_i)
		flag_q <= '0;
	else
		flag_q <= flag_d;
end

// level sources bypass the flag entirely
assign req = ((flag_q & ~LEVEL_MASK) | (irq_level_i & LEVEL_MASK)) & en_q; // R2 R13

always_comb
begin
	found = 1'b0;
	win_d = win_q;
	for (int i = 0; i < N_SRC; i++)
	begin
		if (req[i] && !found)
		begin
			found = 1'b1;
			win_d = SRC_W'(i); // R3
		end
	end
end

// code in the locked section may not be interrupted through the other table
assign lock_sup = (app_boot_lock_bit_i && vector_table_select_q && program_counter_i < BOOT_START) ||
	(boot_section_lock_bit_i && !vector_table_select_q && program_counter_i >= BOOT_START); // R6

assign can_take = st_q == S_IDLE && core_evt_i.boundary && gie_q && found &&
	!core_evt_i.cli && !core_evt_i.sei && !core_evt_i.return_from_irq_instr && !skip_q && !lock_sup; // R2 R16 R19 R24

assign take_clr = (can_take && !LEVEL_MASK[win_d]) ? (N_SRC'(1) << win_d) : '0; // R9

////////////////////////////////////////////////////////////////////////////////
// entry and return sequencer

logic [2:0] cnt_q, cnt_d;
logic [15:0] pc_q, pc_d;
logic [7:0] hi_q, hi_d;
logic take_d, retv_d, hold_d;
logic [15:0] vec_d;
cis_stk_t stk_d;
logic take_q, retv_q, hold_q;
logic [15:0] vec_q, rvec_q, rpc_q, rpc_d;
cis_stk_t stk_q;

always_comb
begin
	st_d = st_q;
	cnt_d = cnt_q;
	pc_d = pc_q;
	hi_d = hi_q;
	gie_d = gie_q;
	sp_d = sp_q;
	skip_d = skip_q;
	take_d = 1'b0;
	retv_d = 1'b0;
	rpc_d = rpc_q;
	vec_d = vec_q;
	stk_d = '0;
	// software writes to bit 7 allow nesting inside a handler
	if (bus_wr && wb_sel_i[0] && wb_adr_i[4:2] == REG_STATUS)
		gie_d = wb_dat_i[GIE_BIT]; // R7 R23
	if (bus_wr && wb_adr_i[4:2] == REG_STACK)
	begin
		if (wb_sel_i[0])
			sp_d[7:0] = wb_dat_i[7:0];
		if (wb_sel_i[1])
			sp_d[15:8] = wb_dat_i[15:8];
	end
	if (core_evt_i.boundary)
		skip_d = 1'b0; // R14 R17
	if (core_evt_i.boundary && core_evt_i.cli)
		gie_d = 1'b0; // R16
	if (core_evt_i.boundary && core_evt_i.sei)
	begin
		gie_d = 1'b1;
		skip_d = 1'b1; // R17
	end
	unique case (st_q)
		S_IDLE:
		begin
			if (can_take)
			begin
				gie_d = 1'b0; // R7
				pc_d = program_counter_i;
				cnt_d = WAKE_CYC - 3'h1;
				st_d = core_evt_i.sleeping ? S_WAKE : S_PUSH_LO; // R20
			end
			else if (core_evt_i.boundary && core_evt_i.return_from_irq_instr)
				st_d = S_POP_HI;
		end
		S_WAKE:
		begin
			cnt_d = cnt_q - 3'h1;
			if (cnt_q == 3'h0)
				st_d = S_PUSH_LO; // R20
		end
		S_PUSH_LO:
		begin
			stk_d = '{we: 1'b1, re: 1'b0, addr: sp_q, wdata: pc_q[7:0]}; // R18
			st_d = S_PUSH_HI;
		end
		S_PUSH_HI:
		begin
			stk_d = '{we: 1'b1, re: 1'b0, addr: sp_q - SP_STEP, wdata: pc_q[15:8]};
			st_d = S_ENT3;
		end
		S_ENT3:
			st_d = S_ENT4;
		S_ENT4:
		begin
			// only the return address goes on the stack, status stays put
			sp_d = sp_q - SP_STEP - SP_STEP; // R15 R22
			take_d = 1'b1;
			vec_d = (vector_table_select_q ? BOOT_START : RESET_SLOT) + {7'h00, VEC_IDX[win_q], 1'b0}; // R1 R4 R25
			st_d = S_IDLE;
		end
		S_POP_HI:
		begin
			stk_d = '{we: 1'b0, re: 1'b1, addr: sp_q + SP_STEP, wdata: 8'h00}; // R21
			st_d = S_POP_LO;
		end
		S_POP_LO:
		begin
			stk_d = '{we: 1'b0, re: 1'b1, addr: sp_q + SP_STEP + SP_STEP, wdata: 8'h00};
			st_d = S_RT3;
		end
		// read data trails the registered strobe by one cycle
		S_RT3:
		begin
			hi_d = stk_rdata_i;
			st_d = S_RT4;
		end
		S_RT4:
		begin
			rpc_d = {hi_q, stk_rdata_i};
			sp_d = sp_q + SP_STEP + SP_STEP; // R21
			gie_d = 1'b1; // R8
			skip_d = 1'b1; // R14
			retv_d = 1'b1;
			st_d = S_IDLE;
		end
		default:
			st_d = S_IDLE;
	endcase
	hold_d = st_d != S_IDLE;
end

always_ff @(posedge clk_i)
begin
	if (rst_i)
	begin
		st_q <= S_IDLE;
		cnt_q <= '0;
		pc_q <= '0;
		hi_q <= '0;
		gie_q <= 1'b0;
		sp_q <= SP_RESET;
		skip_q <= 1'b0;
		win_q <= '0;
		take_q <= 1'b0;
		retv_q <= 1'b0;
		hold_q <= 1'b0;
		vec_q <= RESET_SLOT;
		rvec_q <= RESET_SLOT;
		rpc_q <= '0;
		stk_q <= '0;
	end
	else
	begin
		st_q <= st_d;
		cnt_q <= cnt_d;
		pc_q <= pc_d;
		hi_q <= hi_d;
		gie_q <= gie_d;
		sp_q <= sp_d;
		skip_q <= skip_d;
		if (can_take)
			win_q <= win_d; // R24
		take_q <= take_d;
		retv_q <= retv_d;
		hold_q <= hold_d;
		vec_q <= vec_d;
		rvec_q <= reset_vector_boot_fuse_i ? BOOT_START : RESET_SLOT; // R5
		rpc_q <= rpc_d;
		stk_q <= stk_d;
	end
end

assign core_hold_o = hold_q;
assign irq_take_o = take_q;
assign vec_addr_o = vec_q;
assign rst_vec_o = rvec_q;
assign ret_valid_o = retv_q;
assign ret_pc_o = rpc_q;
assign gie_o = gie_q;
assign stk_o = stk_q;

////////////////////////////////////////////////////////////////////////////////
// assertions

default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);

logic ret_start;
assign ret_start = st_q == S_IDLE && !can_take && core_evt_i.boundary && core_evt_i.return_from_irq_instr;

a_entry_four_cycles: assert property (can_take && !core_evt_i.sleeping |=> // R18 R22
	core_hold_o [*4] ##1 (irq_take_o && !core_hold_o && sp_q == $past(sp_q, 5) - 16'h0002))
	else $error("entry did not finish in four cycles");
a_wake_extra: assert property (can_take && core_evt_i.sleeping |=> // R20
	core_hold_o [*8] ##1 irq_take_o)
	else $error("wake entry not eight cycles");
a_take_clears_gie: assert property (can_take |=> !gie_q) // R7
	else $error("global enable left set at entry");
a_return_four: assert property (ret_start |=> core_hold_o [*4] ##1 // R8 R21
	(ret_valid_o && gie_o && sp_q == $past(sp_q, 5) + 16'h0002))
	else $error("return sequence wrong");
a_needs_enables: assert property (can_take |-> gie_q && (en_q[win_d])) // R2
	else $error("service without enables");
a_lowest_wins: assert property (can_take |-> (req & ((N_SRC'(1) << win_d) - N_SRC'(1))) == '0)
	else $error("lower source skipped"); // R3
a_cli_blocks: assert property (core_evt_i.cli |-> !can_take) // R16
	else $error("service in cli cycle");
a_skip_one: assert property (ret_valid_o |-> skip_q && !can_take) // R14 R17
	else $error("no instruction after return");
a_flag_cleared: assert property (can_take && !LEVEL_MASK[win_d] && !irq_event_i[win_d] |=>
	!flag_q[win_q]) // R9
	else $error("flag not cleared at vectoring");
a_vector_base: assert property (irq_take_o |-> (vec_addr_o >= BOOT_START) == vector_table_select_q) // R4 R25
	else $error("vector outside selected table");

c_entry: cover property (can_take ##5 irq_take_o);
c_wake: cover property (can_take && core_evt_i.sleeping);
c_return: cover property (ret_valid_o);
c_level: cover property (can_take && LEVEL_MASK[win_d]);

endmodule // cis_top

// ===== verification/cis_stack_model.sv
// stack memory model on the far side of the sequencer's stack port
// assumes read data is wanted only in the cycle after a read strobe
`timescale 1ns/100ps
module cis_stack_model
	import cis_pkg::*;
(
	// clock
	input wire logic clk_i,
	// stack port
	input wire cis_stk_t stk_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem_q [0:255];
	logic [7:0] rdata_q = 8'h5a;
	// outside the read slot the byte toggles, so a late sample never passes
	always @(posedge clk_i)
	begin
		if (stk_i.we)
			mem_q[stk_i.addr[7:0]] <= stk_i.wdata;
		rdata_q <= stk_i.re ? mem_q[stk_i.addr[7:0]] : ~rdata_q;
	end
	assign rdata_o = rdata_q;
endmodule // cis_stack_model

// ===== verification/cis_top_test.sv
// self-checking bench of the interrupt sequencer
// assumes cis_pkg and the stack model are compiled first
`timescale 1ns/100ps
module cis_top_test;
	import cis_pkg::*;
	// vec of zero means no entry is expected
	typedef struct {logic [7:0] ev; logic [7:0] en; logic g; logic [15:0] vec; logic [7:0] fl;} cis_row_t;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, fuse = 1'h0;
	logic lock_app = 1'h0, lock_boot = 1'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h3;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic wb_ack_o, core_hold_o, irq_take_o, ret_valid_o, gie_o;
	logic [7:0] irq_event_i = 8'h00, irq_level_i = 8'h00, stk_rdata_i;
	logic [15:0] pc = 16'h0000, vec_addr_o, rst_vec_o, ret_pc_o;
	cis_core_evt_t core_evt_i = '0;
	cis_stk_t stk_o;
	int error_cnt = 0, num_checks = 0, n;
	cis_row_t rows [5] = '{'{8'h01, 8'hff, 1'h1, 16'h0002, 8'h00},
		'{8'h0c, 8'hff, 1'h1, 16'h0006, 8'h08}, '{8'h0c, 8'h08, 1'h1, 16'h0008, 8'h04},
		'{8'h02, 8'h00, 1'h1, 16'h0000, 8'h02}, '{8'h02, 8'hff, 1'h0, 16'h0000, 8'h02}};

	always #12.5 clk_i = ~clk_i;

	cis_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_event_i(irq_event_i),
		.irq_level_i(irq_level_i), .reset_vector_boot_fuse_i(fuse),
		.app_boot_lock_bit_i(lock_app), .boot_section_lock_bit_i(lock_boot),
		.core_evt_i(core_evt_i), .program_counter_i(pc), .core_hold_o(core_hold_o),
		.irq_take_o(irq_take_o), .vec_addr_o(vec_addr_o), .rst_vec_o(rst_vec_o),
		.ret_valid_o(ret_valid_o), .ret_pc_o(ret_pc_o), .gie_o(gie_o), .stk_o(stk_o),
		.stk_rdata_i(stk_rdata_i));
	cis_stack_model u_stk (.clk_i(clk_i), .stk_i(stk_o), .rdata_o(stk_rdata_i));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h, want %h", $time, s, e);
		end
	endtask
	task automatic final_report;
		$display("checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// the request stands until the edge at which ack is sampled high
	task automatic wb(input logic w, input logic [2:0] i, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= {3'h0, i, 2'h0};
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (wb_ack_o !== 1'h1 && k < 20);
		if (wb_ack_o !== 1'h1)
			error_cnt++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask
	// n counts cycles to take or resume, 12 when neither comes
	task automatic bnd(input logic [4:0] e);
		@(posedge clk_i);
		core_evt_i <= e;
		n = 0;
		do
		begin
			@(posedge clk_i);
			core_evt_i <= '0;
			#1;
			n++;
		end
		while (irq_take_o !== 1'h1 && ret_valid_o !== 1'h1 && n < 12);
	endtask
	task automatic fire(input logic [7:0] v);
		@(posedge clk_i);
		irq_event_i <= v;
		@(posedge clk_i);
		irq_event_i <= 8'h00;
	endtask
	task automatic prep(input logic [7:0] en, input logic [7:0] ev, input logic g);
		wb(1'h1, REG_FLAG, 32'hff);
		wb(1'h1, REG_STACK, 32'h100);
		wb(1'h1, REG_ENABLE, en);
		fire(ev);
		wb(1'h1, REG_STATUS, {g, 7'h0});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		#1;
		chk(rst_vec_o, 16'h0000);
		foreach (rows[i])
		begin
			prep(rows[i].en, rows[i].ev, rows[i].g);
			bnd(5'h10);
			chk(n, rows[i].vec != 16'h0000 ? 5 : 12);
			if (rows[i].vec != 16'h0000)
				chk(vec_addr_o, rows[i].vec);
			chk(gie_o, rows[i].g && rows[i].vec == 16'h0000);
			wb(1'h0, REG_FLAG, 32'h0);
			chk(rd, rows[i].fl);
			wb(1'h0, REG_STACK, 32'h0);
			chk(rd, rows[i].vec != 16'h0000 ? 32'hfe : 32'h100);
		end
		prep(8'hff, 8'h30, 1'h1);
		pc <= 16'h1234;
		bnd(5'h11);
		chk(n, 9);
		chk(vec_addr_o, 16'h000a);
		bnd(5'h12);
		chk(n, 5);
		chk(ret_pc_o, pc);
		chk(gie_o, 1'h1);
		wb(1'h0, REG_STACK, 32'h0);
		chk(rd, 32'h100);
		bnd(5'h10);
		chk(n, 12);
		bnd(5'h10);
		chk(vec_addr_o, 16'h000c);
		wb(1'h1, REG_STATUS, 32'h80);
		fire(8'h01);
		bnd(5'h18);
		chk(n, 12);
		chk(gie_o, 1'h0);
		bnd(5'h14);
		chk(gie_o, 1'h1);
		bnd(5'h10);
		chk(n, 12);
		bnd(5'h10);
		chk(vec_addr_o, 16'h0002);
		wb(1'h1, REG_MCU_CTRL, 32'h1);
		wb(1'h1, REG_STATUS, 32'h80);
		fire(8'h01);
		bnd(5'h10);
		chk(vec_addr_o, 16'h3802);
		wb(1'h1, REG_STATUS, 32'h80);
		@(posedge clk_i);
		irq_level_i <= 8'h80;
		bnd(5'h10);
		chk(vec_addr_o, 16'h3810);
		wb(1'h0, 3'h7, 32'h0);
		chk(rd, 32'h0);
		@(posedge clk_i);
		irq_level_i <= 8'h00;
		lock_app <= 1'h1;
		prep(8'hff, 8'h01, 1'h1);
		bnd(5'h10);
		chk(n, 12);
		@(posedge clk_i);
		lock_app <= 1'h0;
		bnd(5'h10);
		chk(vec_addr_o, 16'h3802);
		@(posedge clk_i);
		fuse <= 1'h1;
		rst_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		#1;
		chk(rst_vec_o, 16'h3800);
		@(posedge clk_i);
		lock_boot <= 1'h1;
		pc <= 16'h3900;
		prep(8'hff, 8'h01, 1'h1);
		bnd(5'h10);
		chk(n, 12);
		@(posedge clk_i);
		lock_boot <= 1'h0;
		bnd(5'h10);
		chk(vec_addr_o, 16'h0002);
		final_report;
	end

	// the whole sequence needs well under a thousand cycles
	initial
	begin
		#150000;
		error_cnt++;
		final_report;
	end
endmodule // cis_top_test
